// >>> hdl/pram_xfer_pkg.sv
// constants and carrier types for the process ram transfer engine
package pram_xfer_pkg;

   // -------------------------------------------------------------
   // widths and fifo geometry
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned PTR_W      = 4;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned IRQ_W      = 2;
   localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;

   // -------------------------------------------------------------
   // register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_RD_DATA     = 16'h0000;
   localparam logic [ADDR_W-1:0] OFS_WR_DATA     = 16'h0020;
   localparam logic [ADDR_W-1:0] OFS_RD_ADDR_LEN = 16'h0308;
   localparam logic [ADDR_W-1:0] OFS_RD_CMD      = 16'h030C;
   localparam logic [ADDR_W-1:0] OFS_WR_ADDR_LEN = 16'h0310;
   localparam logic [ADDR_W-1:0] OFS_WR_CMD      = 16'h0314;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 16'h0320;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR   = 16'h0324;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE  = 16'h0328;

   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int unsigned BUSY_BIT  = 31;
   localparam int unsigned ABORT_BIT = 30;
   localparam int unsigned CNT_LSB   = 8;
   localparam int unsigned AVAIL_BIT = 0;
   localparam int unsigned IRQ_RD_DONE = 0;
   localparam int unsigned IRQ_WR_DONE = 1;
   localparam logic [1:0] LANE_LAST = 2'h3;
   localparam logic [1:0] LANE_ZERO = 2'h0;
   localparam logic [ADDR_W-1:0] ONE16  = 16'h0001;
   localparam logic [ADDR_W-1:0] ZERO16 = 16'h0000;
   localparam logic [DATA_W-1:0] ZERO32 = 32'h0000_0000;
   localparam logic [IRQ_W-1:0]  IRQ_NONE = 2'h0;

   // -------------------------------------------------------------
   // carrier types
   // -------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] len;
      logic [ADDR_W-1:0] addr;
   } addr_len_t;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] wdata;
   } core_req_t;

   localparam core_req_t CORE_IDLE = '{rd: 1'b0, wr: 1'b0,
                                       addr: 16'h0000, wdata: 8'h00};
   localparam addr_len_t AL_RESET  = '{len: 16'h0000, addr: 16'h0000};

endpackage : pram_xfer_pkg

// >>> hdl/pram_xfer_engine.sv
// process ram transfer engine: host registers, read and write fifos
// Summary of operation
// - writing busy starts read; self-clears when done
// - abort cancels read, resets fifo and status
// - read word count tracks words held in read fifo; write count shows free words
// - read data-available flag set while read fifo nonempty; write flag set while write fifo not full
// - write length decrements per byte written
// - write address increments per byte written
// - read length decrements, address increments per byte
// - writing write busy starts write; self-clears
`timescale 1ns/1ps
module pram_xfer_engine (
   input  wire logic                                REF_CLK,
   input  wire logic                                RST_N,
   input  wire logic [pram_xfer_pkg::ADDR_W-1:0]    REG_ADDR,
   input  wire logic [pram_xfer_pkg::DATA_W-1:0]    REG_WDATA,
   input  wire logic                                REG_WR,
   input  wire logic                                REG_RD,
   output logic      [pram_xfer_pkg::DATA_W-1:0]    REG_RDATA,
   output pram_xfer_pkg::core_req_t                 CORE_REQ,
   input  wire logic [pram_xfer_pkg::BYTE_W-1:0]    CORE_RDATA,
   output logic                                     IRQ
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [pram_xfer_pkg::PTR_W-1:0] ptr_inc(
      input logic [pram_xfer_pkg::PTR_W-1:0] p);
      ptr_inc = p + 4'h1;
   endfunction : ptr_inc

   function automatic logic reg_hit(input logic [15:0] ofs);
      reg_hit = (REG_ADDR == ofs);
   endfunction : reg_hit

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   pram_xfer_pkg::addr_len_t rd_al;
   pram_xfer_pkg::addr_len_t wr_al;
   logic                     rd_busy;
   logic                     rd_pend;
   logic [1:0]               rd_lane;
   logic [31:0]              rd_word;
   logic [31:0]              next_rd_word;
   logic [31:0]              rd_mem [16];
   logic [3:0]               rd_wp, rd_rp;
   logic [4:0]               rd_cnt;
   logic                     wr_busy;
   logic                     wr_have;
   logic [1:0]               wr_lane;
   logic [31:0]              wr_word;
   logic [31:0]              wr_mem [16];
   logic [3:0]               wr_wp, wr_rp;
   logic [4:0]               wr_cnt;
   logic [4:0]               wr_space;
   logic [1:0]               irq_status, irq_enable, irq_event;
   logic [31:0]              next_rdata;
   logic                     rd_start, rd_abort, wr_start, wr_abort;
   logic                     issue_rd, push_rd, pop_rd, rd_done;
   logic                     issue_wr, load_wr, push_wr, wr_done;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   assign rd_abort = REG_WR && reg_hit(pram_xfer_pkg::OFS_RD_CMD)
                     && REG_WDATA[pram_xfer_pkg::ABORT_BIT];
   assign rd_start = REG_WR && reg_hit(pram_xfer_pkg::OFS_RD_CMD)
                     && REG_WDATA[pram_xfer_pkg::BUSY_BIT]
                     && !rd_busy && !rd_abort;
   assign wr_abort = REG_WR && reg_hit(pram_xfer_pkg::OFS_WR_CMD)
                     && REG_WDATA[pram_xfer_pkg::ABORT_BIT];
   assign wr_start = REG_WR && reg_hit(pram_xfer_pkg::OFS_WR_CMD)
                     && REG_WDATA[pram_xfer_pkg::BUSY_BIT]
                     && !wr_busy && !wr_abort;

   // ----------------------------------------------------------------
   // read engine
   // ----------------------------------------------------------------
   // one byte in flight at a time; only fetch while the fifo has room
   assign issue_rd = rd_busy && !rd_abort && !rd_pend
                     && (rd_al.len != pram_xfer_pkg::ZERO16)
                     && (rd_cnt != pram_xfer_pkg::FIFO_DEPTH);
   assign push_rd  = rd_pend && !rd_abort
                     && ((rd_lane == pram_xfer_pkg::LANE_LAST)
                     || (rd_al.len == pram_xfer_pkg::ZERO16));
   assign pop_rd   = REG_RD && reg_hit(pram_xfer_pkg::OFS_RD_DATA)
                     && (rd_cnt != pram_xfer_pkg::CNT_ZERO);
   assign rd_done  = rd_busy && !rd_abort && !rd_pend
                     && (rd_al.len == pram_xfer_pkg::ZERO16);

   always_comb begin
      next_rd_word = rd_word;
      next_rd_word[{rd_lane, 3'b000} +: 8] = CORE_RDATA;
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_busy <= 1'b0;
      end else if (rd_abort || rd_done) begin
         rd_busy <= 1'b0;
      end else if (rd_start) begin
         rd_busy <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_al <= pram_xfer_pkg::AL_RESET;
      end else if (REG_WR && reg_hit(pram_xfer_pkg::OFS_RD_ADDR_LEN)) begin
         rd_al <= REG_WDATA;
      end else if (issue_rd) begin
         rd_al.len  <= rd_al.len - pram_xfer_pkg::ONE16;
         rd_al.addr <= rd_al.addr + pram_xfer_pkg::ONE16;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_pend <= 1'b0;
         rd_lane <= pram_xfer_pkg::LANE_ZERO;
         rd_word <= pram_xfer_pkg::ZERO32;
      end else if (rd_abort) begin
         rd_pend <= 1'b0;
         rd_lane <= pram_xfer_pkg::LANE_ZERO;
         rd_word <= pram_xfer_pkg::ZERO32;
      end else begin
         rd_pend <= issue_rd;
         if (push_rd) begin
            rd_lane <= pram_xfer_pkg::LANE_ZERO;
            rd_word <= pram_xfer_pkg::ZERO32;
         end else if (rd_pend) begin
            rd_lane <= rd_lane + 2'h1;
            rd_word <= next_rd_word;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (push_rd) begin
         rd_mem[rd_wp] <= next_rd_word;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_wp  <= 4'h0;
         rd_rp  <= 4'h0;
         rd_cnt <= pram_xfer_pkg::CNT_ZERO;
      end else if (rd_abort) begin
         rd_wp  <= 4'h0;
         rd_rp  <= 4'h0;
         rd_cnt <= pram_xfer_pkg::CNT_ZERO;
      end else begin
         if (push_rd) begin
            rd_wp <= ptr_inc(rd_wp);
         end
         if (pop_rd) begin
            rd_rp <= ptr_inc(rd_rp);
         end
         if (push_rd && !pop_rd) begin
            rd_cnt <= rd_cnt + 5'h01;
         end else if (pop_rd && !push_rd) begin
            rd_cnt <= rd_cnt - 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // write engine
   // ----------------------------------------------------------------
   // reads get the core port first; a write byte waits one cycle
   assign load_wr  = wr_busy && !wr_abort && !wr_have
                     && (wr_al.len != pram_xfer_pkg::ZERO16)
                     && (wr_cnt != pram_xfer_pkg::CNT_ZERO);
   assign issue_wr = wr_busy && !wr_abort && wr_have && !issue_rd
                     && (wr_al.len != pram_xfer_pkg::ZERO16);
   assign push_wr  = REG_WR && reg_hit(pram_xfer_pkg::OFS_WR_DATA)
                     && (wr_cnt != pram_xfer_pkg::FIFO_DEPTH);
   assign wr_done  = wr_busy && !wr_abort
                     && (wr_al.len == pram_xfer_pkg::ZERO16);
   assign wr_space = pram_xfer_pkg::FIFO_DEPTH - wr_cnt;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_busy <= 1'b0;
      end else if (wr_abort || wr_done) begin
         wr_busy <= 1'b0;
      end else if (wr_start) begin
         wr_busy <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_al <= pram_xfer_pkg::AL_RESET;
      end else if (REG_WR && reg_hit(pram_xfer_pkg::OFS_WR_ADDR_LEN)) begin
         wr_al <= REG_WDATA;
      end else if (issue_wr) begin
         wr_al.len  <= wr_al.len - pram_xfer_pkg::ONE16;
         wr_al.addr <= wr_al.addr + pram_xfer_pkg::ONE16;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_have <= 1'b0;
         wr_lane <= pram_xfer_pkg::LANE_ZERO;
         wr_word <= pram_xfer_pkg::ZERO32;
      end else if (wr_abort) begin
         wr_have <= 1'b0;
         wr_lane <= pram_xfer_pkg::LANE_ZERO;
      end else if (load_wr) begin
         wr_have <= 1'b1;
         wr_lane <= pram_xfer_pkg::LANE_ZERO;
         wr_word <= wr_mem[wr_rp];
      end else if (issue_wr) begin
         wr_lane <= wr_lane + 2'h1;
         if ((wr_lane == pram_xfer_pkg::LANE_LAST)
             || (wr_al.len == pram_xfer_pkg::ONE16)) begin
            wr_have <= 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (push_wr) begin
         wr_mem[wr_wp] <= REG_WDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_wp  <= 4'h0;
         wr_rp  <= 4'h0;
         wr_cnt <= pram_xfer_pkg::CNT_ZERO;
      end else if (wr_abort) begin
         wr_wp  <= 4'h0;
         wr_rp  <= 4'h0;
         wr_cnt <= pram_xfer_pkg::CNT_ZERO;
      end else begin
         if (push_wr) begin
            wr_wp <= ptr_inc(wr_wp);
         end
         if (load_wr) begin
            wr_rp <= ptr_inc(wr_rp);
         end
         if (push_wr && !load_wr) begin
            wr_cnt <= wr_cnt + 5'h01;
         end else if (load_wr && !push_wr) begin
            wr_cnt <= wr_cnt - 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // core port
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_REQ <= pram_xfer_pkg::CORE_IDLE;
      end else begin
         CORE_REQ.rd    <= issue_rd;
         CORE_REQ.wr    <= issue_wr;
         CORE_REQ.addr  <= issue_rd ? rd_al.addr : wr_al.addr;
         CORE_REQ.wdata <= wr_word[{wr_lane, 3'b000} +: 8];
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   assign irq_event = {wr_done, rd_done};

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_status <= pram_xfer_pkg::IRQ_NONE;
         irq_enable <= pram_xfer_pkg::IRQ_NONE;
      end else begin
         // a new event wins over a clear in the same cycle
         if (REG_WR && reg_hit(pram_xfer_pkg::OFS_IRQ_CLEAR)) begin
            irq_status <= (irq_status & ~REG_WDATA[1:0]) | irq_event;
         end else begin
            irq_status <= irq_status | irq_event;
         end
         if (REG_WR && reg_hit(pram_xfer_pkg::OFS_IRQ_ENABLE)) begin
            irq_enable <= REG_WDATA[1:0];
         end
      end
   end

   assign IRQ = |(irq_status & irq_enable);

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = pram_xfer_pkg::ZERO32;
      if (reg_hit(pram_xfer_pkg::OFS_RD_DATA)) begin
         next_rdata = pop_rd ? rd_mem[rd_rp] : pram_xfer_pkg::ZERO32;
      end else if (reg_hit(pram_xfer_pkg::OFS_RD_ADDR_LEN)) begin
         next_rdata = rd_al;
      end else if (reg_hit(pram_xfer_pkg::OFS_RD_CMD)) begin
         next_rdata[pram_xfer_pkg::BUSY_BIT] = rd_busy;
         next_rdata[pram_xfer_pkg::CNT_LSB +: 5] = rd_cnt;
         next_rdata[pram_xfer_pkg::AVAIL_BIT] =
            (rd_cnt != pram_xfer_pkg::CNT_ZERO);
      end else if (reg_hit(pram_xfer_pkg::OFS_WR_ADDR_LEN)) begin
         next_rdata = wr_al;
      end else if (reg_hit(pram_xfer_pkg::OFS_WR_CMD)) begin
         next_rdata[pram_xfer_pkg::BUSY_BIT] = wr_busy;
         next_rdata[pram_xfer_pkg::CNT_LSB +: 5] = wr_space;
         next_rdata[pram_xfer_pkg::AVAIL_BIT] =
            (wr_space != pram_xfer_pkg::CNT_ZERO);
      end else if (reg_hit(pram_xfer_pkg::OFS_IRQ_STATUS)) begin
         next_rdata[1:0] = irq_status;
      end else if (reg_hit(pram_xfer_pkg::OFS_IRQ_ENABLE)) begin
         next_rdata[1:0] = irq_enable;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= pram_xfer_pkg::ZERO32;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end else begin
         REG_RDATA <= pram_xfer_pkg::ZERO32;
      end
   end

endmodule : pram_xfer_engine

// >>> dv/pram_core_model.sv
// process ram model answering the engine's byte requests
`timescale 1ns/1ps
module pram_core_model (
   input  wire logic                            REF_CLK,
   input  wire pram_xfer_pkg::core_req_t        CORE_REQ,
   output logic [pram_xfer_pkg::BYTE_W-1:0]     CORE_RDATA
);
   // ------------------------------------------------------------
   // storage and byte port
   // ------------------------------------------------------------
   logic [7:0] mem [0:4095];

   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ 8'h3C;
      end
   end

   // a byte stands while its read strobe stands, as the engine takes
   // it at the end of that cycle; otherwise the line shows the inverse
   always_comb begin
      CORE_RDATA = ~mem[CORE_REQ.addr[11:0]];
      if (CORE_REQ.rd) begin
         CORE_RDATA = mem[CORE_REQ.addr[11:0]];
      end
   end

   always @(posedge REF_CLK) begin
      if (CORE_REQ.wr) begin
         mem[CORE_REQ.addr[11:0]] <= CORE_REQ.wdata;
      end
   end
endmodule : pram_core_model

// >>> dv/pram_xfer_sva.sv
// port checker for the process ram transfer engine
`timescale 1ns/1ps
module pram_xfer_sva (
   input wire logic                             REF_CLK,
   input wire logic                             RST_N,
   input wire logic [pram_xfer_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic                             REG_RD,
   input wire logic [pram_xfer_pkg::DATA_W-1:0] REG_RDATA,
   input wire pram_xfer_pkg::core_req_t         CORE_REQ
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   logic cmd_rd;
   assign cmd_rd = REG_RD && (REG_ADDR == pram_xfer_pkg::OFS_RD_CMD);

   reset_idle_a: assert property (
      $rose(RST_N) |-> CORE_REQ == pram_xfer_pkg::CORE_IDLE
                       && REG_RDATA == 32'h0000_0000)
      else $error("outputs not idle after reset");
   rd_spacing_a: assert property (
      CORE_REQ.rd |=> !CORE_REQ.rd)
      else $error("core reads closer than two cycles");
   strobe_excl_a: assert property (
      !(CORE_REQ.rd && CORE_REQ.wr))
      else $error("core read and write together");
   rd_ascend_a: assert property (
      CORE_REQ.rd ##2 CORE_REQ.rd |->
         CORE_REQ.addr == $past(CORE_REQ.addr, 2) + 16'h0001)
      else $error("read address not ascending");
   wr_ascend_a: assert property (
      CORE_REQ.wr ##1 CORE_REQ.wr |->
         CORE_REQ.addr == $past(CORE_REQ.addr) + 16'h0001)
      else $error("write address not ascending");
   avail_flag_a: assert property (
      cmd_rd |=> REG_RDATA[0] == (REG_RDATA[12:8] != 5'h00))
      else $error("data flag disagrees with count");
   count_range_a: assert property (
      cmd_rd |=> REG_RDATA[12:8] <= pram_xfer_pkg::FIFO_DEPTH
                 && REG_RDATA[29:13] == 17'h0_0000
                 && REG_RDATA[7:1] == 7'h00)
      else $error("count out of range or reserved set");
   abort_zero_a: assert property (
      cmd_rd |=> !REG_RDATA[30])
      else $error("abort bit reads back set");
endmodule : pram_xfer_sva

// >>> dv/process_ram_transfer_engine_tb.sv
// self-checking bench for the process ram transfer engine
`timescale 1ns/1ps
module process_ram_transfer_engine_tb;
   // ------------------------------------------------------------
   // signals, instances, access tasks
   // ------------------------------------------------------------
   logic                      ref_clk;
   logic                      rst_n;
   logic [15:0]               reg_addr;
   logic [31:0]               reg_wdata;
   logic [31:0]               reg_rdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic                      irq;
   logic [7:0]                core_rdata;
   logic [31:0]               d;
   pram_xfer_pkg::core_req_t  core_req;
   int                        miscompares;
   int                        n_compared;

   pram_xfer_engine i_pram_xfer_engine (.REF_CLK(ref_clk), .RST_N(rst_n),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CORE_REQ(core_req),
      .CORE_RDATA(core_rdata), .IRQ(irq));
   pram_core_model i_pram_core_model (.REF_CLK(ref_clk),
      .CORE_REQ(core_req), .CORE_RDATA(core_rdata));

   function automatic logic [7:0] pb(input logic [15:0] a);
      return a[7:0] ^ 8'h3C;
   endfunction : pb

   task automatic chk(input string w, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask : chk

   task automatic summarize();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic rdchk(input logic [15:0] a, input logic [31:0] e,
                        input string w);
      logic [31:0] v;
      rd(a, v);
      chk(w, v, e);
   endtask : rdchk

   // polls a command register until its busy bit drops
   task automatic wait_idle(input logic [15:0] a);
      for (int i = 0; i < 100; i++) begin
         rd(a, d);
         if (!d[31]) begin
            return;
         end
      end
      miscompares++;
      summarize();
   endtask : wait_idle

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdchk(pram_xfer_pkg::OFS_RD_CMD, 32'h0000_0000, "rdcmd rst");
      rdchk(pram_xfer_pkg::OFS_WR_ADDR_LEN, 32'h0, "wral rst");
      rdchk(pram_xfer_pkg::OFS_WR_CMD, 32'h0000_1001, "wrcmd rst");
      rdchk(16'h0100, 32'h0000_0000, "unmapped");
      chk("irq rst", {31'h0, irq}, 32'h0);
      // six bytes ending at the top of process ram
      wr(pram_xfer_pkg::OFS_RD_ADDR_LEN, 32'h0006_1FFA);
      wr(pram_xfer_pkg::OFS_RD_CMD, 32'h8000_0000);
      rd(pram_xfer_pkg::OFS_RD_CMD, d);
      chk("busy set", {31'h0, d[31]}, 32'h1);
      wait_idle(pram_xfer_pkg::OFS_RD_CMD);
      wr(pram_xfer_pkg::OFS_RD_CMD, 32'h0000_0000);
      rdchk(pram_xfer_pkg::OFS_RD_CMD, 32'h0000_0201, "two");
      rdchk(pram_xfer_pkg::OFS_RD_ADDR_LEN, 32'h0000_2000, "ral");
      rdchk(pram_xfer_pkg::OFS_RD_DATA, {pb(16'h1FFD), pb(16'h1FFC),
         pb(16'h1FFB), pb(16'h1FFA)}, "word0");
      rdchk(pram_xfer_pkg::OFS_RD_CMD, 32'h0000_0101, "one");
      rdchk(pram_xfer_pkg::OFS_RD_DATA, {16'h0000, pb(16'h1FFF),
         pb(16'h1FFE)}, "word1");
      rdchk(pram_xfer_pkg::OFS_RD_CMD, 32'h0000_0000, "empty");
      rdchk(pram_xfer_pkg::OFS_RD_DATA, 32'h0000_0000, "pop empty");
      // abort a long read in mid-run
      wr(pram_xfer_pkg::OFS_RD_ADDR_LEN, 32'h0040_1000);
      wr(pram_xfer_pkg::OFS_RD_CMD, 32'h8000_0000);
      repeat (20) @(posedge ref_clk);
      rd(pram_xfer_pkg::OFS_RD_CMD, d);
      chk("has data", {31'h0, d[0]}, 32'h1);
      wr(pram_xfer_pkg::OFS_RD_CMD, 32'h4000_0000);
      rdchk(pram_xfer_pkg::OFS_RD_CMD, 32'h0, "aborted");
      rdchk(pram_xfer_pkg::OFS_RD_DATA, 32'h0, "flushed");
      // five bytes written from two fifo words
      wr(pram_xfer_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
      wr(pram_xfer_pkg::OFS_WR_ADDR_LEN, 32'h0005_1010);
      wr(pram_xfer_pkg::OFS_WR_DATA, 32'h4433_2211);
      wr(pram_xfer_pkg::OFS_WR_DATA, 32'h8877_6655);
      wr(pram_xfer_pkg::OFS_WR_CMD, 32'h8000_0000);
      wait_idle(pram_xfer_pkg::OFS_WR_CMD);
      chk("wr fifo", d, 32'h0000_1001);
      rdchk(pram_xfer_pkg::OFS_WR_ADDR_LEN, 32'h1015, "wal");
      for (int i = 0; i < 6; i++) begin
         chk("pram byte", {24'h0, i_pram_core_model.mem[16 + i]},
             (i < 5) ? 32'(8'h11 * (i + 1)) : {24'h0, pb(16'h1015)});
      end
      // interrupt raise, mask and clear
      chk("irq on", {31'h0, irq}, 32'h1);
      rdchk(pram_xfer_pkg::OFS_IRQ_STATUS, 32'h3, "status");
      wr(pram_xfer_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
      rdchk(pram_xfer_pkg::OFS_IRQ_STATUS, 32'h2, "clear one");
      wr(pram_xfer_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
      rdchk(pram_xfer_pkg::OFS_IRQ_ENABLE, 32'h1, "enable");
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(pram_xfer_pkg::OFS_IRQ_CLEAR, 32'h0000_0002);
      rdchk(pram_xfer_pkg::OFS_IRQ_STATUS, 32'h0, "clear two");
      summarize();
   end
endmodule : process_ram_transfer_engine_tb

bind pram_xfer_engine pram_xfer_sva i_pram_xfer_sva (.REF_CLK(REF_CLK),
   .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .CORE_REQ(CORE_REQ));
